// file: inc/cmd_decoder_pkg.sv
package cmd_decoder_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ = 10_000_000;
	localparam int BAUD_BPS = 19200;
	localparam int BIT_CYC = CLK_HZ / BAUD_BPS;
	localparam int HALF_CYC = BIT_CYC / 2;
	localparam int STRAP_WAIT = 2;
	// ----------------------------------------
	// frame layout
	// ----------------------------------------
	localparam int NPORTS = 10;
	localparam int OPEN_BIT = 7;
	localparam int DIR_BIT = 6;
	localparam int OVR_BIT = 6;
	localparam int PDIR_BIT = 6;
	localparam logic [5:0] OP_PORT_CTRL = 6'h2c;
	localparam logic [5:0] OP_PORT_STAT = 6'h2d;
	// ----------------------------------------
	// defaults
	// ----------------------------------------
	localparam logic [9:0] TX_OPEN_RST = 10'h3ff;
	localparam logic [9:0] RX_OPEN_RST = 10'h001;
	localparam logic [4:0] UNIT_RST = 5'h01;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_TX_OPEN = 8'h04;
	localparam logic [7:0] ADDR_RX_OPEN = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam int CTRL_RESTORE_BIT = 8;
	// ----------------------------------------
	// states
	// ----------------------------------------
	typedef enum logic [3:0] {
		RX_IDLE = 4'b0001,
		RX_START = 4'b0010,
		RX_DATA = 4'b0100,
		RX_STOP = 4'b1000
	} rx_state_e;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b01,
		TX_SHIFT = 2'b10
	} tx_state_e;
	typedef enum logic [3:0] {
		P_IDLE = 4'b0001,
		P_B1 = 4'b0010,
		P_B2 = 4'b0100,
		P_B3 = 4'b1000
	} parse_state_e;
endpackage

// file: rtl/serial_command_decoder.sv
`timescale 1ns/1ps
module serial_command_decoder (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_rxd,
	output logic o_txd,
	input wire logic i_factory_btn,
	output logic o_defaults_restore,
	input wire logic i_panel_valid,
	input wire logic [5:0] i_panel_opcode,
	input wire logic [6:0] i_panel_input,
	input wire logic [6:0] i_panel_output,
	output logic o_panel_ready,
	output logic [7:0] o_fwd_data,
	output logic o_fwd_valid,
	output logic [9:0] o_fwd_ports,
	input wire logic i_ret_valid,
	input wire logic [3:0] i_ret_port,
	input wire logic [7:0] i_ret_data,
	output logic o_ret_ready,
	output logic [9:0] o_rx_open
);
	// ----------------------------------------
	// receiver
	// ----------------------------------------
	cmd_decoder_pkg::rx_state_e rs_q, rs_d;
	logic rxs1_q, rxs2_q;
	logic [9:0] rc_q, rc_d;
	logic [2:0] rn_q, rn_d;
	logic [7:0] rsh_q, rsh_d;
	logic rv_q, rv_d;
	logic [7:0] ferr_q, ferr_d;

	always_comb begin
		rs_d = rs_q;
		rc_d = rc_q + 10'h001;
		rn_d = rn_q;
		rsh_d = rsh_q;
		rv_d = 1'b0;
		ferr_d = ferr_q;
		case (rs_q)
			cmd_decoder_pkg::RX_IDLE: begin
				rc_d = '0;
				if (!rxs2_q) rs_d = cmd_decoder_pkg::RX_START;
			end
			cmd_decoder_pkg::RX_START: begin
				if (rc_q == 10'(cmd_decoder_pkg::HALF_CYC - 1)) begin
					rc_d = '0;
					rn_d = '0;
					// a glitch shorter than half a bit is not a start
					rs_d = rxs2_q ? cmd_decoder_pkg::RX_IDLE : cmd_decoder_pkg::RX_DATA;
				end
			end
			cmd_decoder_pkg::RX_DATA: begin
				if (rc_q == 10'(cmd_decoder_pkg::BIT_CYC - 1)) begin
					rc_d = '0;
					rsh_d = {rxs2_q, rsh_q[7:1]};
					rn_d = rn_q + 3'h1;
					if (rn_q == 3'h7) rs_d = cmd_decoder_pkg::RX_STOP;
				end
			end
			cmd_decoder_pkg::RX_STOP: begin
				if (rc_q == 10'(cmd_decoder_pkg::BIT_CYC - 1)) begin
					rs_d = cmd_decoder_pkg::RX_IDLE;
					if (rxs2_q) rv_d = 1'b1;
					else ferr_d = ferr_q + 8'h01;
				end
			end
			default: rs_d = cmd_decoder_pkg::RX_IDLE;
		endcase
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rxs1_q <= 1'b1;
			rxs2_q <= 1'b1;
			rs_q <= cmd_decoder_pkg::RX_IDLE;
			rc_q <= '0;
			rn_q <= '0;
			rsh_q <= '0;
			rv_q <= 1'b0;
			ferr_q <= '0;
		end else begin
			rxs1_q <= i_rxd;
			rxs2_q <= rxs1_q;
			rs_q <= rs_d;
			rc_q <= rc_d;
			rn_q <= rn_d;
			rsh_q <= rsh_d;
			rv_q <= rv_d;
			ferr_q <= ferr_d;
		end
	end

	// ----------------------------------------
	// parser and path setup
	// ----------------------------------------
	cmd_decoder_pkg::parse_state_e ps_q, ps_d;
	logic [7:0] f0_q, f0_d, f1_q, f1_d, f2_q, f2_d;
	logic [9:0] txo_q, txo_d, rxo_q, rxo_d;
	logic [4:0] unit_q, unit_d;
	logic [7:0] exec_q, exec_d, disc_q, disc_d;
	logic [7:0] fwd_q, fwd_d;
	logic fwv_q, fwv_d;
	logic pend_q, pend_d, take_reply;
	logic [31:0] rep_q, rep_d;
	logic btn1_q, btn2_q;
	logic [1:0] sc_q, sc_d;
	logic rst_q, rst_d;
	logic [31:0] rd_q, rd_d;
	logic acc, hit;
	logic [5:0] port;
	logic [9:0] sel;
	logic is_cmd, match, ok, st;

	always_comb begin
		acc = i_psel && i_penable;
		hit = (i_paddr == cmd_decoder_pkg::ADDR_CTRL) || (i_paddr == cmd_decoder_pkg::ADDR_TX_OPEN)
			|| (i_paddr == cmd_decoder_pkg::ADDR_RX_OPEN) || (i_paddr == cmd_decoder_pkg::ADDR_STATUS);
		port = f2_q[5:0];
		for (int i = 0; i < cmd_decoder_pkg::NPORTS; i++) begin
			sel[i] = (port == 6'h00) || (port == 6'(i + 1));
		end
		is_cmd = !rsh_q[cmd_decoder_pkg::OPEN_BIT] && !rsh_q[cmd_decoder_pkg::DIR_BIT]
			&& ((rsh_q[5:0] == cmd_decoder_pkg::OP_PORT_CTRL)
			|| (rsh_q[5:0] == cmd_decoder_pkg::OP_PORT_STAT));
		match = rsh_q[4:0] == unit_q;
		st = f2_q[cmd_decoder_pkg::PDIR_BIT] ? |(rxo_q & sel) : |(txo_q & sel);
		if (f0_q[5:0] == cmd_decoder_pkg::OP_PORT_CTRL)
			ok = (port <= 6'(cmd_decoder_pkg::NPORTS)) && (f1_q[6:1] == 6'h00);
		else
			ok = (port != 6'h00) && (port <= 6'(cmd_decoder_pkg::NPORTS));
		ps_d = ps_q;
		f0_d = f0_q;
		f1_d = f1_q;
		f2_d = f2_q;
		txo_d = txo_q;
		rxo_d = rxo_q;
		unit_d = unit_q;
		exec_d = exec_q;
		disc_d = disc_q;
		fwd_d = fwd_q;
		fwv_d = 1'b0;
		rep_d = rep_q;
		pend_d = pend_q && !take_reply;
		sc_d = sc_q;
		rst_d = 1'b0;
		rd_d = rd_q;
		// apb writes have the lower priority against a frame in the same cycle
		if (acc && i_pwrite) begin
			case (i_paddr)
				cmd_decoder_pkg::ADDR_CTRL: begin
					unit_d = i_pwdata[4:0];
					rst_d = i_pwdata[cmd_decoder_pkg::CTRL_RESTORE_BIT];
				end
				cmd_decoder_pkg::ADDR_TX_OPEN: txo_d = i_pwdata[9:0];
				cmd_decoder_pkg::ADDR_RX_OPEN: rxo_d = i_pwdata[9:0];
				default: ;
			endcase
		end
		if (sc_q != 2'(cmd_decoder_pkg::STRAP_WAIT + 1)) sc_d = sc_q + 2'h1;
		if (sc_q == 2'(cmd_decoder_pkg::STRAP_WAIT) && btn2_q) rst_d = 1'b1;
		if (rst_d) begin
			txo_d = cmd_decoder_pkg::TX_OPEN_RST;
			rxo_d = cmd_decoder_pkg::RX_OPEN_RST;
			unit_d = cmd_decoder_pkg::UNIT_RST;
		end
		if (rv_q) begin
			if (is_cmd) begin
				f0_d = rsh_q;
				ps_d = cmd_decoder_pkg::P_B1;
			end else if (ps_q == cmd_decoder_pkg::P_IDLE || !rsh_q[cmd_decoder_pkg::OPEN_BIT]) begin
				fwd_d = rsh_q;
				fwv_d = 1'b1;
				ps_d = cmd_decoder_pkg::P_IDLE;
			end else begin
				case (ps_q)
					cmd_decoder_pkg::P_B1: begin
						f1_d = rsh_q;
						ps_d = cmd_decoder_pkg::P_B2;
					end
					cmd_decoder_pkg::P_B2: begin
						f2_d = rsh_q;
						ps_d = cmd_decoder_pkg::P_B3;
					end
					cmd_decoder_pkg::P_B3: begin
						ps_d = cmd_decoder_pkg::P_IDLE;
						if ((match || rsh_q[cmd_decoder_pkg::OVR_BIT]) && ok) begin
							exec_d = exec_q + 8'h01;
							if (f0_q[5:0] == cmd_decoder_pkg::OP_PORT_CTRL) begin
								if (!f2_q[cmd_decoder_pkg::PDIR_BIT])
									txo_d = f1_q[0] ? (txo_q | sel) : (txo_q & ~sel);
								else if (!f1_q[0])
									rxo_d = rxo_q & ~sel;
								else
									// open-all on receive keeps it exclusive: first port
									rxo_d = (port == 6'h00) ? cmd_decoder_pkg::RX_OPEN_RST : sel;
							end
							if (match) begin
								pend_d = 1'b1;
								rep_d = {f0_q | 8'h40, f1_q, f2_q, rsh_q};
								if (f0_q[5:0] == cmd_decoder_pkg::OP_PORT_STAT)
									rep_d[23:16] = {7'h40, st};
							end
						end else begin
							disc_d = disc_q + 8'h01;
						end
					end
					default: ps_d = cmd_decoder_pkg::P_IDLE;
				endcase
			end
		end
		if (i_psel && !i_penable) begin
			case (i_paddr)
				cmd_decoder_pkg::ADDR_CTRL: rd_d = {27'h0, unit_q};
				cmd_decoder_pkg::ADDR_TX_OPEN: rd_d = {22'h0, txo_q};
				cmd_decoder_pkg::ADDR_RX_OPEN: rd_d = {22'h0, rxo_q};
				cmd_decoder_pkg::ADDR_STATUS: rd_d = {8'h00, ferr_q, disc_q, exec_q};
				default: rd_d = '0;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			ps_q <= cmd_decoder_pkg::P_IDLE;
			f0_q <= '0;
			f1_q <= '0;
			f2_q <= '0;
			txo_q <= cmd_decoder_pkg::TX_OPEN_RST;
			rxo_q <= cmd_decoder_pkg::RX_OPEN_RST;
			unit_q <= cmd_decoder_pkg::UNIT_RST;
			exec_q <= '0;
			disc_q <= '0;
			fwd_q <= '0;
			fwv_q <= 1'b0;
			pend_q <= 1'b0;
			rep_q <= '0;
			btn1_q <= 1'b0;
			btn2_q <= 1'b0;
			sc_q <= '0;
			rst_q <= 1'b0;
			rd_q <= '0;
		end else begin
			ps_q <= ps_d;
			f0_q <= f0_d;
			f1_q <= f1_d;
			f2_q <= f2_d;
			txo_q <= txo_d;
			rxo_q <= rxo_d;
			unit_q <= unit_d;
			exec_q <= exec_d;
			disc_q <= disc_d;
			fwd_q <= fwd_d;
			fwv_q <= fwv_d;
			pend_q <= pend_d;
			rep_q <= rep_d;
			btn1_q <= i_factory_btn;
			btn2_q <= btn1_q;
			sc_q <= sc_d;
			rst_q <= rst_d;
			rd_q <= rd_d;
		end
	end

	// ----------------------------------------
	// transmitter
	// ----------------------------------------
	cmd_decoder_pkg::tx_state_e ts_q, ts_d;
	logic [9:0] tsh_q, tsh_d, tc_q, tc_d;
	logic [3:0] tn_q, tn_d;
	logic [31:0] fb_q, fb_d;
	logic [2:0] fl_q, fl_d;
	logic txd_q, txd_d;

	always_comb begin
		ts_d = ts_q;
		tsh_d = tsh_q;
		tc_d = tc_q + 10'h001;
		tn_d = tn_q;
		fb_d = fb_q;
		fl_d = fl_q;
		take_reply = 1'b0;
		o_panel_ready = 1'b0;
		o_ret_ready = 1'b0;
		case (ts_q)
			cmd_decoder_pkg::TX_IDLE: begin
				tc_d = '0;
				tn_d = '0;
				if (fl_q != 3'h0) begin
					tsh_d = {1'b1, fb_q[31:24], 1'b0};
					fb_d = {fb_q[23:0], 8'h00};
					fl_d = fl_q - 3'h1;
					ts_d = cmd_decoder_pkg::TX_SHIFT;
				end else if (pend_q) begin
					take_reply = 1'b1;
					fb_d = rep_q;
					fl_d = 3'h4;
				end else if (i_panel_valid) begin
					o_panel_ready = 1'b1;
					fb_d = {2'b01, i_panel_opcode, 1'b1, i_panel_input, 1'b1, i_panel_output,
						3'b100, unit_q};
					fl_d = 3'h4;
				end else if (i_ret_valid) begin
					// returns from closed ports are consumed and dropped
					o_ret_ready = 1'b1;
					if (i_ret_port != 4'h0 && i_ret_port <= 4'(cmd_decoder_pkg::NPORTS)
						&& rxo_q[i_ret_port - 4'h1]) begin
						fb_d = {i_ret_data, 24'h0};
						fl_d = 3'h1;
					end
				end
			end
			cmd_decoder_pkg::TX_SHIFT: begin
				if (tc_q == 10'(cmd_decoder_pkg::BIT_CYC - 1)) begin
					tc_d = '0;
					tsh_d = {1'b1, tsh_q[9:1]};
					tn_d = tn_q + 4'h1;
					if (tn_q == 4'h9) ts_d = cmd_decoder_pkg::TX_IDLE;
				end
			end
			default: ts_d = cmd_decoder_pkg::TX_IDLE;
		endcase
		txd_d = (ts_d == cmd_decoder_pkg::TX_SHIFT) ? tsh_d[0] : 1'b1;
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			ts_q <= cmd_decoder_pkg::TX_IDLE;
			tsh_q <= '1;
			tc_q <= '0;
			tn_q <= '0;
			fb_q <= '0;
			fl_q <= '0;
			txd_q <= 1'b1;
		end else begin
			ts_q <= ts_d;
			tsh_q <= tsh_d;
			tc_q <= tc_d;
			tn_q <= tn_d;
			fb_q <= fb_d;
			fl_q <= fl_d;
			txd_q <= txd_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign o_txd = txd_q;
	assign o_prdata = rd_q;
	assign o_pready = 1'b1;
	assign o_pslverr = acc && !hit;
	assign o_defaults_restore = rst_q;
	assign o_fwd_data = fwd_q;
	assign o_fwd_valid = fwv_q;
	assign o_fwd_ports = txo_q;
	assign o_rx_open = rxo_q;
endmodule // serial_command_decoder

// file: test/serial_command_decoder_sva.sv
`timescale 1ns/1ps
module serial_command_decoder_sva (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic o_txd,
	input wire logic o_defaults_restore,
	input wire logic o_fwd_valid,
	input wire logic [9:0] o_fwd_ports,
	input wire logic [9:0] o_rx_open
);
	localparam int BIT = cmd_decoder_pkg::BIT_CYC;
	logic [15:0] low_d, low_q;
	logic acc;
	assign acc = i_psel && i_penable;
	// low run length on the line, cleared while high
	always_comb low_d = o_txd ? 16'h0000 : low_q + 16'h0001;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) low_q <= 16'h0000;
		else low_q <= low_d;
	end
	default clocking @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);
	AST_PREADY: assert property (acc |-> o_pready) else $error("ready low in access");
	AST_SLVERR: assert property (o_pslverr == (acc && !(i_paddr inside
		{8'h00, 8'h04, 8'h08, 8'h0c}))) else $error("slave error wrong");
	AST_MASK_UPPER: assert property (acc && (i_paddr == 8'h04 || i_paddr == 8'h08)
		|-> o_prdata[31:10] == 22'h000000) else $error("mask upper bits set");
	AST_FWD_PULSE: assert property (o_fwd_valid |=> !o_fwd_valid) else $error("fwd not pulse");
	AST_RESTORE_PULSE: assert property (o_defaults_restore |=> !o_defaults_restore)
		else $error("restore not pulse");
	AST_RESTORE_DEFAULTS: assert property (o_defaults_restore |-> ##[0:1]
		(o_fwd_ports == 10'h3ff && o_rx_open == 10'h001)) else $error("defaults wrong");
	AST_RX_EXCLUSIVE: assert property ($onehot0(o_rx_open)) else $error("rx not exclusive");
	AST_TXD_BIT_TIME: assert property ($rose(o_txd) |->
		(low_q % BIT == 0 && low_q <= 9 * BIT)) else $error("bit time wrong");
	cover property (o_fwd_valid);
	cover property (o_defaults_restore);
	cover property (o_pslverr);
	cover property ($fell(o_rx_open[0]));
endmodule // serial_command_decoder_sva
bind serial_command_decoder serial_command_decoder_sva serial_command_decoder_sva_inst (
	.i_core_clk(i_core_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
	.i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.o_txd(o_txd), .o_defaults_restore(o_defaults_restore), .o_fwd_valid(o_fwd_valid),
	.o_fwd_ports(o_fwd_ports), .o_rx_open(o_rx_open));

// file: test/host_link_model.sv
`timescale 1ns/1ps
module host_link_model (
	input wire logic i_clk,
	input wire logic i_line,
	output logic o_line
);
	localparam int BIT = cmd_decoder_pkg::BIT_CYC;
	logic [7:0] rx_q[$];
	logic [7:0] b;
	int stop_err = 0;
	initial o_line = 1'b1;
	// lsb first, eight data, no parity, one stop
	task automatic send_byte(input logic [7:0] v);
		logic [9:0] f;
		f = {1'b1, v, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge i_clk);
			o_line <= f[i];
			repeat (BIT - 1) @(posedge i_clk);
		end
	endtask
	// opening byte 00+op, then flagged bytes, unit last
	task automatic send_frame(input logic [5:0] op, input logic [6:0] a, input logic [6:0] o,
		input logic [6:0] u);
		send_byte({2'b00, op});
		send_byte({1'b1, a});
		send_byte({1'b1, o});
		send_byte({1'b1, u});
	endtask
	// mid-bit sampling of the device line
	always begin
		@(negedge i_line);
		repeat (BIT / 2) @(posedge i_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge i_clk);
			b[i] = i_line;
		end
		repeat (BIT) @(posedge i_clk);
		if (i_line !== 1'b1) stop_err++;
		rx_q.push_back(b);
	end
endmodule // host_link_model

// file: test/serial_command_decoder_tb.sv
`timescale 1ns/1ps
module serial_command_decoder_tb;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, btn = 1'b1;
	logic [7:0] paddr = 8'h00, rdat = 8'h33, fdat, fwd_last;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, rxd, txd, restore, er, pv = 1'b0, prdy, rv = 1'b0, rrdy, fval;
	logic [5:0] pop = 6'h01;
	logic [6:0] pin = 7'h03, pout = 7'h04;
	logic [3:0] rport = 4'h2;
	logic [9:0] fports, rxo;
	int error_cnt = 0, comparisons = 0, fwd_cnt = 0, rst_cnt = 0;
	always #50 clk = ~clk;
	serial_command_decoder serial_command_decoder_inst (.i_core_clk(clk), .i_rst(rst),
		.i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_rxd(rxd), .o_txd(txd),
		.i_factory_btn(btn), .o_defaults_restore(restore), .i_panel_valid(pv),
		.i_panel_opcode(pop), .i_panel_input(pin), .i_panel_output(pout), .o_panel_ready(prdy),
		.o_fwd_data(fdat), .o_fwd_valid(fval), .o_fwd_ports(fports), .i_ret_valid(rv),
		.i_ret_port(rport), .i_ret_data(rdat), .o_ret_ready(rrdy), .o_rx_open(rxo));
	host_link_model host_link_model_inst (.i_clk(clk), .i_line(txd), .o_line(rxd));
	always @(posedge clk) begin
		if (fval === 1'b1) fwd_cnt++;
		if (fval === 1'b1) fwd_last = fdat;
		if (restore === 1'b1) rst_cnt++;
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic chk_q(input logic [7:0] e[]);
		while (host_link_model_inst.rx_q.size() < e.size()) @(posedge clk);
		foreach (e[i]) chk(host_link_model_inst.rx_q.pop_front(), e[i]);
	endtask
	task automatic summarize();
		if (error_cnt == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic sc_strap();
		repeat (6) @(posedge clk);
		chk(rst_cnt, 1);
		btn <= 1'b0;
	endtask
	task automatic sc_regs();
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h1);
		apb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h3ff);
		apb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h1);
		apb(1'b0, 8'h10, 32'h0);
		chk({rd[30:0], er}, 32'h1);
		apb(1'b1, 8'h04, 32'h5);
		// the mask lands at the access edge, so look one edge later
		@(posedge clk);
		chk(fports, 10'h005);
		apb(1'b1, 8'h00, 32'h100);
		repeat (2) @(posedge clk);
		chk({rxo, fports}, {10'h001, 10'h3ff});
		chk(rst_cnt, 2);
	endtask
	task automatic sc_cmds();
		host_link_model_inst.send_frame(6'h2c, 7'h01, 7'h42, 7'h01);
		host_link_model_inst.send_frame(6'h2d, 7'h00, 7'h42, 7'h01);
		// override to unit 2 closes all transmit paths but must not reply
		host_link_model_inst.send_frame(6'h2c, 7'h00, 7'h00, 7'h42);
		chk_q('{8'h6c, 8'h81, 8'hc2, 8'h81, 8'h6d, 8'h81, 8'hc2, 8'h81});
		chk(fports, 10'h000);
		chk(rxo, 10'h002);
		chk(host_link_model_inst.stop_err, 0);
	endtask
	// wrong unit must neither act nor reply, else its reply lands before the return byte
	task automatic sc_mix();
		fork
			begin
				host_link_model_inst.send_frame(6'h2c, 7'h01, 7'h00, 7'h02);
				host_link_model_inst.send_byte(8'h55);
			end
			begin
				pv <= 1'b1;
				do @(posedge clk); while (prdy !== 1'b1);
				pv <= 1'b0;
				rv <= 1'b1;
				do @(posedge clk); while (rrdy !== 1'b1);
				rv <= 1'b0;
			end
		join
		chk_q('{8'h41, 8'h83, 8'h84, 8'h81, 8'h33});
		chk({fwd_cnt[7:0], fwd_last}, {8'h01, 8'h55});
		chk(fports, 10'h000);
		// three executed, one discarded, no framing errors
		apb(1'b0, 8'h0c, 32'h0);
		chk(rd, 32'h00000103);
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		sc_strap();
		sc_regs();
		sc_cmds();
		sc_mix();
		summarize();
	end
	initial begin
		repeat (96000) @(posedge clk);
		error_cnt++;
		summarize();
	end
endmodule // serial_command_decoder_tb
